// file: smb_pkg.sv
// Constants shared by the status and event monitor bank
package smb_pkg;
  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register addresses
  localparam logic [15:0] ADDR_XFER       = 16'h0005;
  localparam logic [15:0] ADDR_MASK_CEV   = 16'h010A;
  localparam logic [15:0] ADDR_MASK_AB    = 16'h010B;
  localparam logic [15:0] ADDR_MASK_CD    = 16'h010C;
  localparam logic [15:0] ADDR_CLR_ALL    = 16'h0A05;
  localparam logic [15:0] ADDR_CLR_CEV    = 16'h0A06;
  localparam logic [15:0] ADDR_CLR_AB     = 16'h0A07;
  localparam logic [15:0] ADDR_CLR_CD     = 16'h0A08;
  localparam logic [15:0] ADDR_NVM_STAT   = 16'h0D00;
  localparam logic [15:0] ADDR_SYS_STAT   = 16'h0D01;
  localparam logic [15:0] ADDR_REF_A_STAT = 16'h0D02;
  localparam logic [15:0] ADDR_REF_B_STAT = 16'h0D03;
  localparam logic [15:0] ADDR_REF_C_STAT = 16'h0D04;
  localparam logic [15:0] ADDR_REF_D_STAT = 16'h0D05;
  localparam logic [15:0] ADDR_CEV_MON    = 16'h0D08;
  localparam logic [15:0] ADDR_AB_MON     = 16'h0D09;
  localparam logic [15:0] ADDR_CD_MON     = 16'h0D0A;

  // Transfer strobe value and clear-all bit
  localparam logic [7:0] XFER_VAL    = 8'h01;
  localparam int         CLR_ALL_BIT = 0;

  // Reset values
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] REG_RST  = 8'h00;

  // Nonvolatile memory status fields
  localparam int NVM_SAVE_BIT  = 0;
  localparam int NVM_LOAD_BIT  = 1;
  localparam int NVM_FAULT_BIT = 2;

  // System clock status fields
  localparam int SYS_LOCK_BIT   = 0;
  localparam int SYS_STABLE_BIT = 1;
  localparam int SYS_CHAIN0_BIT = 2;
  localparam int SYS_CHAIN1_BIT = 3;

  // Reference status fields
  localparam int REF_SLOW_BIT  = 0;
  localparam int REF_FAST_BIT  = 1;
  localparam int REF_FAULT_BIT = 2;
  localparam int REF_VALID_BIT = 3;
  localparam int REF_ACT0_BIT  = 4;
  localparam int REF_ACT1_BIT  = 5;

  // Common event fields
  localparam int CEV_NVM_DONE_BIT  = 0;
  localparam int CEV_NVM_FAULT_BIT = 1;
  localparam int CEV_WDOG_BIT      = 3;
  localparam int CEV_LOCK_BIT      = 4;
  localparam int CEV_STABLE_BIT    = 5;
  localparam int CEV_UNLOCK_BIT    = 6;

  // Reference event fields, low nibble; high nibble adds REV_HI_OFS
  localparam int REV_FAULT_BIT   = 0;
  localparam int REV_RECOVER_BIT = 1;
  localparam int REV_VALID_BIT   = 2;
  localparam int REV_HI_OFS      = 4;
endpackage

// file: smb_sticky.sv
// Sticky event flag byte with mask and clear
`timescale 1ns/1ps
`default_nettype none
module smb_sticky (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [7:0] evt_in,
  input  wire logic [7:0] mask_in,
  input  wire logic [7:0] clr_in,
  output logic      [7:0] flags_q
);
  logic [7:0] flags_d;

  // Clear first, then set, so a new event wins over its clear
  always_comb begin
    flags_d = (flags_q & ~clr_in) | (evt_in & ~mask_in);
  end

  // Flags hold until reset or clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_q <= smb_pkg::REG_RST;
    end else if (ce) begin
      flags_q <= flags_d;
    end
  end
endmodule
`default_nettype wire

// file: smb_ref_stat.sv
// Status byte and edge events for one input reference
`timescale 1ns/1ps
`default_nettype none
module smb_ref_stat (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       valid,
  input  wire logic       fault,
  input  wire logic       fast,
  input  wire logic       slow,
  input  wire logic       act_first,
  input  wire logic       act_second,
  output logic      [7:0] status,
  output logic            evt_fault,
  output logic            evt_recover,
  output logic            evt_valid
);
  logic valid_q;
  logic fault_q;

  // Live status byte, reserved bits zero
  always_comb begin
    status = smb_pkg::REG_RST;
    status[smb_pkg::REF_ACT1_BIT]  = act_second;
    status[smb_pkg::REF_ACT0_BIT]  = act_first;
    status[smb_pkg::REF_VALID_BIT] = valid;
    status[smb_pkg::REF_FAULT_BIT] = fault;
    status[smb_pkg::REF_FAST_BIT]  = fast;
    status[smb_pkg::REF_SLOW_BIT]  = slow;
  end

  // Previous levels for edge detection
  always_ff @(posedge mclk) begin
    if (rst) begin
      valid_q <= 1'b0;
      fault_q <= 1'b0;
    end else if (ce) begin
      valid_q <= valid;
      fault_q <= fault;
    end
  end

  // New fault, fault recovery, validation
  assign evt_fault   = fault & ~fault_q;
  assign evt_recover = ~fault & fault_q;
  assign evt_valid   = valid & ~valid_q;
endmodule
`default_nettype wire

// file: smb_status_bank.sv
// Status readback and sticky event monitor register bank
`timescale 1ns/1ps
`default_nettype none
module smb_status_bank (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        system_clock_multiplier_locked,
  input  wire logic        system_clock_multiplier_stable,
  input  wire logic        first_analog_locked,
  input  wire logic        second_analog_locked,
  input  wire logic        first_digital_locked,
  input  wire logic        second_digital_locked,
  input  wire logic        nvm_save_busy,
  input  wire logic        nvm_load_busy,
  input  wire logic        nvm_done,
  input  wire logic        nvm_fault,
  input  wire logic        watchdog_expired,
  input  wire logic [3:0]  ref_valid,
  input  wire logic [3:0]  ref_fault,
  input  wire logic [3:0]  ref_fast,
  input  wire logic [3:0]  ref_slow,
  input  wire logic [3:0]  first_loop_ref_active,
  input  wire logic [3:0]  second_loop_ref_active
);
  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic       xfer_go;
  logic       clr_all;
  logic       wr_hit;
  logic       op_start;
  logic       lock_q;
  logic       stable_q;
  logic       busy_q;
  logic       nvm_fault_q;
  logic [7:0] live_nvm;
  logic [7:0] live_sys;
  logic [7:0] ref_live [4];
  logic [3:0] ref_evt_fault;
  logic [3:0] ref_evt_recover;
  logic [3:0] ref_evt_valid;
  logic [7:0] snap_nvm_q;
  logic [7:0] snap_sys_q;
  logic [7:0] snap_ref_q [4];
  logic [7:0] mask_cev_q;
  logic [7:0] mask_ab_q;
  logic [7:0] mask_cd_q;
  logic [7:0] evt_cev;
  logic [7:0] evt_ab;
  logic [7:0] evt_cd;
  logic [7:0] clr_cev;
  logic [7:0] clr_ab;
  logic [7:0] clr_cd;
  logic [7:0] cev_q;
  logic [7:0] ab_q;
  logic [7:0] cd_q;
  logic [7:0] rdata_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Write decode
  assign wr_hit  = ce & reg_wr;
  assign xfer_go = wr_hit & (reg_addr == smb_pkg::ADDR_XFER)
                   & (reg_wdata == smb_pkg::XFER_VAL);
  assign clr_all = wr_hit & (reg_addr == smb_pkg::ADDR_CLR_ALL)
                   & reg_wdata[smb_pkg::CLR_ALL_BIT];

  // Clear vectors, one-cycle pulses from write-one strobes
  always_comb begin
    clr_cev = '0;
    clr_ab  = '0;
    clr_cd  = '0;
    if (clr_all) begin
      clr_cev = '1;
      clr_ab  = '1;
      clr_cd  = '1;
    end else if (wr_hit) begin
      if (reg_addr == smb_pkg::ADDR_CLR_CEV) clr_cev = reg_wdata;
      if (reg_addr == smb_pkg::ADDR_CLR_AB)  clr_ab  = reg_wdata;
      if (reg_addr == smb_pkg::ADDR_CLR_CD)  clr_cd  = reg_wdata;
    end
  end

  // Mask registers, writable and readable
  always_ff @(posedge mclk) begin
    if (rst) begin
      mask_cev_q <= smb_pkg::MASK_RST;
      mask_ab_q  <= smb_pkg::MASK_RST;
      mask_cd_q  <= smb_pkg::MASK_RST;
    end else if (wr_hit) begin
      if (reg_addr == smb_pkg::ADDR_MASK_CEV) mask_cev_q <= reg_wdata;
      if (reg_addr == smb_pkg::ADDR_MASK_AB)  mask_ab_q  <= reg_wdata;
      if (reg_addr == smb_pkg::ADDR_MASK_CD)  mask_cd_q  <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Memory transfer fault flag
  assign op_start = (nvm_save_busy | nvm_load_busy) & ~busy_q;

  // Held until the next save or load starts; a new fault wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      nvm_fault_q <= 1'b0;
      busy_q      <= 1'b0;
    end else if (ce) begin
      busy_q <= nvm_save_busy | nvm_load_busy;
      if (nvm_fault) begin
        nvm_fault_q <= 1'b1;
      end else if (op_start) begin
        nvm_fault_q <= 1'b0;
      end
    end
  end

  // Live memory and clock status bytes
  always_comb begin
    live_nvm = smb_pkg::REG_RST;
    live_nvm[smb_pkg::NVM_FAULT_BIT] = nvm_fault_q;
    live_nvm[smb_pkg::NVM_LOAD_BIT]  = nvm_load_busy;
    live_nvm[smb_pkg::NVM_SAVE_BIT]  = nvm_save_busy;
    live_sys = smb_pkg::REG_RST;
    live_sys[smb_pkg::SYS_CHAIN1_BIT] = system_clock_multiplier_locked & second_analog_locked
                                        & second_digital_locked;
    live_sys[smb_pkg::SYS_CHAIN0_BIT] = system_clock_multiplier_locked & first_analog_locked
                                        & first_digital_locked;
    live_sys[smb_pkg::SYS_STABLE_BIT] = system_clock_multiplier_stable;
    live_sys[smb_pkg::SYS_LOCK_BIT]   = system_clock_multiplier_locked;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-reference status and edges, A to D
  for (genvar i = 0; i < 4; i++) begin : g_ref
    smb_ref_stat u_ref (
      .mclk        (mclk),
      .rst         (rst),
      .ce          (ce),
      .valid       (ref_valid[i]),
      .fault       (ref_fault[i]),
      .fast        (ref_fast[i]),
      .slow        (ref_slow[i]),
      .act_first   (first_loop_ref_active[i]),
      .act_second  (second_loop_ref_active[i]),
      .status      (ref_live[i]),
      .evt_fault   (ref_evt_fault[i]),
      .evt_recover (ref_evt_recover[i]),
      .evt_valid   (ref_evt_valid[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Snapshot of status, refreshed only by the transfer strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      snap_nvm_q <= smb_pkg::REG_RST;
      snap_sys_q <= smb_pkg::REG_RST;
      for (int k = 0; k < 4; k++) begin
        snap_ref_q[k] <= smb_pkg::REG_RST;
      end
    end else if (xfer_go) begin
      snap_nvm_q <= live_nvm;
      snap_sys_q <= live_sys;
      for (int k = 0; k < 4; k++) begin
        snap_ref_q[k] <= ref_live[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Previous system clock levels for edge events
  always_ff @(posedge mclk) begin
    if (rst) begin
      lock_q   <= 1'b0;
      stable_q <= 1'b0;
    end else if (ce) begin
      lock_q   <= system_clock_multiplier_locked;
      stable_q <= system_clock_multiplier_stable;
    end
  end

  // Event vectors, reserved positions stay zero
  always_comb begin
    evt_cev = '0;
    evt_cev[smb_pkg::CEV_UNLOCK_BIT]    = lock_q & ~system_clock_multiplier_locked;
    evt_cev[smb_pkg::CEV_LOCK_BIT]      = ~lock_q & system_clock_multiplier_locked;
    evt_cev[smb_pkg::CEV_STABLE_BIT]    = ~stable_q & system_clock_multiplier_stable;
    evt_cev[smb_pkg::CEV_WDOG_BIT]      = watchdog_expired;
    evt_cev[smb_pkg::CEV_NVM_DONE_BIT]  = nvm_done;
    evt_cev[smb_pkg::CEV_NVM_FAULT_BIT] = nvm_fault;
    evt_ab = '0;
    evt_cd = '0;
    evt_ab[smb_pkg::REV_FAULT_BIT]   = ref_evt_fault[0];
    evt_ab[smb_pkg::REV_RECOVER_BIT] = ref_evt_recover[0];
    evt_ab[smb_pkg::REV_VALID_BIT]   = ref_evt_valid[0];
    evt_ab[smb_pkg::REV_FAULT_BIT + smb_pkg::REV_HI_OFS]   = ref_evt_fault[1];
    evt_ab[smb_pkg::REV_RECOVER_BIT + smb_pkg::REV_HI_OFS] = ref_evt_recover[1];
    evt_ab[smb_pkg::REV_VALID_BIT + smb_pkg::REV_HI_OFS]   = ref_evt_valid[1];
    evt_cd[smb_pkg::REV_FAULT_BIT]   = ref_evt_fault[2];
    evt_cd[smb_pkg::REV_RECOVER_BIT] = ref_evt_recover[2];
    evt_cd[smb_pkg::REV_VALID_BIT]   = ref_evt_valid[2];
    evt_cd[smb_pkg::REV_FAULT_BIT + smb_pkg::REV_HI_OFS]   = ref_evt_fault[3];
    evt_cd[smb_pkg::REV_RECOVER_BIT + smb_pkg::REV_HI_OFS] = ref_evt_recover[3];
    evt_cd[smb_pkg::REV_VALID_BIT + smb_pkg::REV_HI_OFS]   = ref_evt_valid[3];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky event monitors
  smb_sticky u_cev (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .evt_in  (evt_cev),
    .mask_in (mask_cev_q),
    .clr_in  (clr_cev),
    .flags_q (cev_q)
  );

  smb_sticky u_ab (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .evt_in  (evt_ab),
    .mask_in (mask_ab_q),
    .clr_in  (clr_ab),
    .flags_q (ab_q)
  );

  smb_sticky u_cd (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .evt_in  (evt_cd),
    .mask_in (mask_cd_q),
    .clr_in  (clr_cd),
    .flags_q (cd_q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped and write-only addresses read zero
  always_comb begin
    rdata_d = smb_pkg::REG_RST;
    if (reg_rd) begin
      case (reg_addr)
        smb_pkg::ADDR_NVM_STAT:   rdata_d = snap_nvm_q;
        smb_pkg::ADDR_SYS_STAT:   rdata_d = snap_sys_q;
        smb_pkg::ADDR_REF_A_STAT: rdata_d = snap_ref_q[0];
        smb_pkg::ADDR_REF_B_STAT: rdata_d = snap_ref_q[1];
        smb_pkg::ADDR_REF_C_STAT: rdata_d = snap_ref_q[2];
        smb_pkg::ADDR_REF_D_STAT: rdata_d = snap_ref_q[3];
        smb_pkg::ADDR_CEV_MON:    rdata_d = cev_q;
        smb_pkg::ADDR_AB_MON:     rdata_d = ab_q;
        smb_pkg::ADDR_CD_MON:     rdata_d = cd_q;
        smb_pkg::ADDR_MASK_CEV:   rdata_d = mask_cev_q;
        smb_pkg::ADDR_MASK_AB:    rdata_d = mask_ab_q;
        smb_pkg::ADDR_MASK_CD:    rdata_d = mask_cd_q;
        default:                  rdata_d = smb_pkg::REG_RST;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= smb_pkg::REG_RST;
    end else if (ce) begin
      reg_rdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_xfer_capture_sys: assert property (xfer_go |=> snap_sys_q == $past(live_sys))
    else $error("system status not captured on transfer strobe");
  a_ro_write_ignored: assert property (!xfer_go |=> $stable(snap_nvm_q)
                                       && $stable(snap_sys_q))
    else $error("status snapshot changed without transfer strobe");
  a_nvm_fault_set: assert property (ce && nvm_fault |=> nvm_fault_q)
    else $error("memory fault flag not set");
  a_nvm_busy_bits: assert property (xfer_go |=>
    snap_nvm_q[smb_pkg::NVM_LOAD_BIT] == $past(nvm_load_busy)
    && snap_nvm_q[smb_pkg::NVM_SAVE_BIT] == $past(nvm_save_busy))
    else $error("memory busy bits wrong");
  a_chain_lock_bits: assert property (xfer_go |=>
    snap_sys_q[smb_pkg::SYS_CHAIN1_BIT] == ($past(system_clock_multiplier_locked)
      && $past(second_analog_locked) && $past(second_digital_locked))
    && snap_sys_q[smb_pkg::SYS_CHAIN0_BIT] == ($past(system_clock_multiplier_locked)
      && $past(first_analog_locked) && $past(first_digital_locked)))
    else $error("loop chain lock bits wrong");
  a_unlock_latch: assert property (ce && lock_q && !system_clock_multiplier_locked
    && !mask_cev_q[smb_pkg::CEV_UNLOCK_BIT] |=> cev_q[smb_pkg::CEV_UNLOCK_BIT])
    else $error("lock loss event not latched");
  a_stable_latch: assert property (ce && !stable_q && system_clock_multiplier_stable
    && !mask_cev_q[smb_pkg::CEV_STABLE_BIT] |=> cev_q[smb_pkg::CEV_STABLE_BIT])
    else $error("stability event not latched");
  a_watchdog_latch: assert property (ce && watchdog_expired
    && !mask_cev_q[smb_pkg::CEV_WDOG_BIT] |=> cev_q[smb_pkg::CEV_WDOG_BIT])
    else $error("watchdog event not latched");
  a_mask_blocks_set: assert property (!cev_q[smb_pkg::CEV_WDOG_BIT]
    && mask_cev_q[smb_pkg::CEV_WDOG_BIT] |=> !cev_q[smb_pkg::CEV_WDOG_BIT])
    else $error("masked event latched");
  a_event_holds: assert property (cev_q[smb_pkg::CEV_NVM_DONE_BIT]
    && !clr_cev[smb_pkg::CEV_NVM_DONE_BIT] |=> cev_q[smb_pkg::CEV_NVM_DONE_BIT])
    else $error("event bit dropped without clear");
  a_ref_fault_latch: assert property (ce && ref_evt_fault[3]
    && !mask_cd_q[smb_pkg::REV_FAULT_BIT + smb_pkg::REV_HI_OFS]
    |=> cd_q[smb_pkg::REV_FAULT_BIT + smb_pkg::REV_HI_OFS])
    else $error("reference D fault event not latched");
  a_ref_recover_latch: assert property (ce && ref_evt_recover[0]
    && !mask_ab_q[smb_pkg::REV_RECOVER_BIT] |=> ab_q[smb_pkg::REV_RECOVER_BIT])
    else $error("reference A recovery event not latched");
  a_reserved_zero: assert property (cev_q[7] == 1'b0 && cev_q[2] == 1'b0 && ab_q[3] == 1'b0
                                    && cd_q[7] == 1'b0)
    else $error("reserved event bit set");
  a_read_window: assert property (ce && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");

  c_xfer_then_read: cover property (xfer_go ##2
                                    (ce && reg_rd && reg_addr == smb_pkg::ADDR_SYS_STAT));
  c_event_cleared: cover property (cev_q[4] ##1 clr_all ##1 !cev_q[4]);
  c_ref_recover: cover property (ab_q[1] && ab_q[0]);
  c_masked_event: cover property (ce && watchdog_expired && mask_cev_q[3]);
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking testbench for the status and event monitor bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        mclk = 1'b0;
  logic        rst, ce, reg_wr, reg_rd;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, prev;
  logic        system_clock_multiplier_locked, system_clock_multiplier_stable, first_analog_locked, second_analog_locked;
  logic        first_digital_locked, second_digital_locked, nvm_save_busy, nvm_load_busy;
  logic        nvm_done, nvm_fault, watchdog_expired;
  logic [3:0]  ref_valid, ref_fault, ref_fast, ref_slow;
  logic [3:0]  first_loop_ref_active, second_loop_ref_active;
  int          n_fail, n_compared;
  integer      seed;

  smb_status_bank u_smb_status_bank (
    .mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .system_clock_multiplier_locked(system_clock_multiplier_locked), .system_clock_multiplier_stable(system_clock_multiplier_stable),
    .first_analog_locked(first_analog_locked), .second_analog_locked(second_analog_locked),
    .first_digital_locked(first_digital_locked),
    .second_digital_locked(second_digital_locked),
    .nvm_save_busy(nvm_save_busy), .nvm_load_busy(nvm_load_busy), .nvm_done(nvm_done),
    .nvm_fault(nvm_fault), .watchdog_expired(watchdog_expired), .ref_valid(ref_valid),
    .ref_fault(ref_fault), .ref_fast(ref_fast), .ref_slow(ref_slow),
    .first_loop_ref_active(first_loop_ref_active),
    .second_loop_ref_active(second_loop_ref_active)
  );

  // 125 MHz clock
  always #4 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////
  // Expected values and checks
  function automatic logic [7:0] e_sys();
    return {4'h0, system_clock_multiplier_locked & second_analog_locked & second_digital_locked,
            system_clock_multiplier_locked & first_analog_locked & first_digital_locked,
            system_clock_multiplier_stable, system_clock_multiplier_locked};
  endfunction

  function automatic logic [7:0] e_ref(input int r);
    return {2'b00, second_loop_ref_active[r], first_loop_ref_active[r], ref_valid[r],
            ref_fault[r], ref_fast[r], ref_slow[r]};
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      n_fail++;
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycles and event stimulus
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input string n, input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(n, e, reg_rdata);
  endtask

  task automatic fire(input int b);
    @(posedge mclk);
    case (b)
      0: nvm_done <= 1'b1;
      1: nvm_fault <= 1'b1;
      3: watchdog_expired <= 1'b1;
      4: system_clock_multiplier_locked <= 1'b1;
      5: system_clock_multiplier_stable <= 1'b1;
      default: system_clock_multiplier_locked <= 1'b0;
    endcase
    @(posedge mclk);
    nvm_done <= 1'b0;
    nvm_fault <= 1'b0;
    watchdog_expired <= 1'b0;
  endtask

  task automatic rfire(input int r, input int k);
    @(posedge mclk);
    if (k == 0) ref_fault[r] <= 1'b1;
    else if (k == 1) ref_fault[r] <= 1'b0;
    else ref_valid[r] <= 1'b1;
  endtask

  task automatic levels(input logic z);
    @(posedge mclk);
    {system_clock_multiplier_locked, system_clock_multiplier_stable, first_analog_locked, second_analog_locked} <=
      z ? 4'h0 : 4'($random(seed));
    {first_digital_locked, second_digital_locked, nvm_save_busy, nvm_load_busy} <=
      z ? 4'h0 : 4'($random(seed));
    {ref_valid, ref_fault, ref_fast, ref_slow} <= z ? 16'h0000 : 16'($random(seed));
    {first_loop_ref_active, second_loop_ref_active} <= z ? 8'h00 : 8'($random(seed));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Bound on the whole run
  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    end_of_test();
  end

  // Main sequence
  initial begin
    seed = 32'hD2A9;
    {rst, ce, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 1'b1, 26'h0};
    {system_clock_multiplier_locked, system_clock_multiplier_stable, first_analog_locked, second_analog_locked} = 4'h0;
    {first_digital_locked, second_digital_locked, nvm_save_busy, nvm_load_busy} = 4'h0;
    {nvm_done, nvm_fault, watchdog_expired} = 3'h0;
    {ref_valid, ref_fault, ref_fast, ref_slow} = 16'h0000;
    {first_loop_ref_active, second_loop_ref_active} = 8'h00;
    n_fail = 0;
    n_compared = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    // Reset values of every status and monitor byte, and the common event mask
    for (int i = 0; i < 11; i++) begin
      rd("reset", (i < 6) ? 16'h0D00 + 16'(i) : 16'h0D02 + 16'(i), 8'h00);
    end
    rd("mask reset", smb_pkg::ADDR_MASK_CEV, 8'h00);
    // Random status snapshots
    repeat (24) begin
      levels(1'b0);
      wr(smb_pkg::ADDR_XFER, smb_pkg::XFER_VAL);
      rd("nvm status", smb_pkg::ADDR_NVM_STAT,
         {5'h00, 1'b0, nvm_load_busy, nvm_save_busy});
      rd("sys status", smb_pkg::ADDR_SYS_STAT, e_sys());
      for (int r = 0; r < 4; r++) begin
        rd("ref status", smb_pkg::ADDR_REF_A_STAT + 16'(r), e_ref(r));
      end
    end
    @(posedge mclk);
    #1 chk("idle rdata", 8'h00, reg_rdata);
    // Snapshot holds without a transfer strobe
    prev = e_sys();
    levels(1'b0);
    wr(smb_pkg::ADDR_SYS_STAT, 8'hFF);
    wr(smb_pkg::ADDR_XFER, 8'h02);
    rd("sys frozen", smb_pkg::ADDR_SYS_STAT, prev);
    rd("unmapped", 16'h1234, 8'h00);
    // Memory fault status sticky until next operation starts
    levels(1'b1);
    fire(1);
    wr(smb_pkg::ADDR_XFER, smb_pkg::XFER_VAL);
    rd("nvm fault", smb_pkg::ADDR_NVM_STAT, 8'h04);
    @(posedge mclk);
    nvm_save_busy <= 1'b1;
    wr(smb_pkg::ADDR_XFER, smb_pkg::XFER_VAL);
    rd("nvm restart", smb_pkg::ADDR_NVM_STAT, 8'h01);
    @(posedge mclk);
    nvm_save_busy <= 1'b0;
    // Each common event alone
    repeat (2) @(posedge mclk);
    wr(smb_pkg::ADDR_CLR_ALL, 8'h01);
    for (int b = 0; b < 7; b++) begin
      if (b != 2) begin
        wr(smb_pkg::ADDR_CLR_CEV, 8'hFF);
        fire(b);
        rd("common event", smb_pkg::ADDR_CEV_MON, 8'h01 << b);
      end
    end
    // Reference fault, recovery and validation, sticky accumulation
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 3; k++) begin
        rfire(r, k);
        rd("ref event", smb_pkg::ADDR_AB_MON + 16'(r / 2),
           8'((8'h07 >> (2 - k)) << (4 * (r % 2)) | ((r % 2) ? 8'h07 : 8'h00)));
      end
    end
    // Per-register selective clears
    wr(smb_pkg::ADDR_CLR_CD, 8'h0F);
    rd("cd clear", smb_pkg::ADDR_CD_MON, 8'h70);
    wr(smb_pkg::ADDR_CLR_AB, 8'hF0);
    rd("ab clear", smb_pkg::ADDR_AB_MON, 8'h07);
    // Masked events never latch; faults raised first so recovery can follow
    rfire(0, 0);
    rfire(1, 0);
    wr(smb_pkg::ADDR_CLR_ALL, 8'h01);
    wr(smb_pkg::ADDR_MASK_CEV, 8'hFF);
    rd("mask readback", smb_pkg::ADDR_MASK_CEV, 8'hFF);
    wr(smb_pkg::ADDR_MASK_AB, 8'h0F);
    fire(3);
    rfire(0, 1);
    rfire(1, 1);
    rd("masked common", smb_pkg::ADDR_CEV_MON, 8'h00);
    rd("masked ab", smb_pkg::ADDR_AB_MON, 8'h20);
    // Selective clear, ignored writes and clear-all
    wr(smb_pkg::ADDR_MASK_CEV, 8'h00);
    fire(0);
    fire(3);
    wr(smb_pkg::ADDR_CEV_MON, 8'hFF);
    wr(smb_pkg::ADDR_CLR_CEV, 8'h08);
    rd("partial clear", smb_pkg::ADDR_CEV_MON, 8'h01);
    wr(smb_pkg::ADDR_CLR_ALL, 8'h00);
    rd("clear none", smb_pkg::ADDR_CEV_MON, 8'h01);
    wr(smb_pkg::ADDR_CLR_ALL, 8'h01);
    rd("clear all", smb_pkg::ADDR_AB_MON, 8'h00);
    // Pulse lost while clock enable is low
    @(posedge mclk);
    ce <= 1'b0;
    fire(3);
    ce <= 1'b1;
    rd("ce low", smb_pkg::ADDR_CEV_MON, 8'h00);
    // Reset in mid-run clears flags and masks
    levels(1'b1);
    fire(3);
    rd("flag before reset", smb_pkg::ADDR_CEV_MON, 8'h08);
    wr(smb_pkg::ADDR_MASK_CD, 8'hA5);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd("reset flags", smb_pkg::ADDR_CEV_MON, 8'h00);
    rd("reset mask", smb_pkg::ADDR_MASK_AB, 8'h00);
    rd("reset mask cd", smb_pkg::ADDR_MASK_CD, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
